// ===== logic/vcr_pkg.sv
// Package holding the register map, field positions and reset values of the codec control bank.
package vcr_pkg;
   localparam logic [3:0] ADDR_ZERO   = 4'h0;
   localparam logic [3:0] ADDR_POWER  = 4'h1;
   localparam logic [3:0] ADDR_FILT   = 4'h2;
   localparam logic [3:0] ADDR_PREDIV = 4'h3;
   localparam logic [3:0] ADDR_MULT   = 4'h4;
   localparam logic [3:0] ADDR_MIX    = 4'h5;
   localparam logic [3:0] ADDR_ADC    = 4'h6;
   localparam logic [3:0] ADDR_DAC    = 4'h7;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] ADDR_ATTEN  = 4'h9;

   localparam logic [7:0] RST_POWER  = 8'h00;
   localparam logic [7:0] RST_FILT   = 8'h00;
   localparam logic [7:0] RST_PREDIV = 8'h00;
   localparam logic [7:0] RST_MULT   = 8'h00;
   localparam logic [7:0] RST_MIX    = 8'h47;
   localparam logic [7:0] RST_ADC    = 8'h5c;
   localparam logic [7:0] RST_DAC    = 8'h5c;
   localparam logic [7:0] RST_ATTEN  = 8'h00;

   // Writable-bit masks; reserved bits read as zero.
   localparam logic [7:0] MASK_POWER = 8'h1f;
   localparam logic [7:0] MASK_FILT  = 8'h1e;
   localparam logic [7:0] MASK_VOL   = 8'h7f;
   localparam logic [7:0] MASK_ATTEN = 8'h0f;

   localparam int BIT_SOFT_RESET  = 7;
   localparam int BIT_SPK_DRIVE   = 4;
   localparam int BIT_LINE_DRIVE  = 3;
   localparam int BIT_HSET_DRIVE  = 2;
   localparam int BIT_MIC_BIAS    = 1;
   localparam int BIT_SLEEP       = 0;
   localparam int BIT_HP_BYPASS   = 4;
   localparam int BIT_PLL_DIV10   = 3;
   localparam int BIT_ALOOP       = 2;
   localparam int BIT_MLOOP       = 1;
   localparam int BIT_LINE_MUTE   = 5;
   localparam int BIT_MIC_MUTE    = 2;
   localparam int BIT_HSET_MUTE   = 1;
   localparam int BIT_IIR         = 0;
   localparam int BIT_OUT_HI      = 1;
   localparam int BIT_OUT_LO      = 0;
   localparam int BIT_SHORT_L     = 7;
   localparam int BIT_SHORT_R     = 6;
   localparam int BIT_SHORT_LINE  = 5;
   localparam int POS_LINE_GAIN   = 6;
   localparam int POS_MIC_GAIN    = 3;
   localparam int POS_PGA_GAIN    = 2;
   localparam int POS_LINE_ATTEN  = 2;
   localparam int POS_SPK_ATTEN   = 0;
endpackage

// ===== logic/vcr_regs.sv
// Control and status register bank of the voiceband codec.
`timescale 1ns/1ps
module vcr_regs (
   input  wire logic       I_CLK,
   input  wire logic       I_RESET_N,
   input  wire logic       I_WR_EN,
   input  wire logic       I_RD_EN,
   input  wire logic [3:0] I_ADDR,
   input  wire logic [7:0] I_WDATA,
   input  wire logic       I_SHORT_SPK_L,
   input  wire logic       I_SHORT_SPK_R,
   input  wire logic       I_SHORT_LINE,
   output logic      [7:0] O_RDATA,
   output logic            O_SPK_DRIVE_EN,
   output logic            O_LINE_DRIVE_EN,
   output logic            O_HSET_DRIVE_EN,
   output logic            O_MIC_BIAS_OFF,
   output logic            O_CHIP_SLEEP,
   output logic            O_HIGHPASS_BYPASS,
   output logic            O_PLL_DIV10,
   output logic            O_ANALOG_LOOPBACK,
   output logic            O_MOD_LOOPBACK,
   output logic      [8:0] O_PLL_PREDIV_FACTOR,
   output logic      [8:0] O_PLL_MULT_FACTOR,
   output logic            O_PLL_BYPASS,
   output logic            O_PLL_UPDATE,
   output logic      [1:0] O_LINE_IN_GAIN,
   output logic            O_LINE_IN_TO_MIX,
   output logic      [1:0] O_MIC_GAIN,
   output logic            O_MIC_TO_MIX,
   output logic            O_HSET_IN_TO_MIX,
   output logic            O_IIR_SELECT,
   output logic      [4:0] O_ADC_PGA_GAIN,
   output logic      [4:0] O_DAC_PGA_GAIN,
   output logic            O_LINE_OUT_ACTIVE,
   output logic            O_HSET_OUT_ACTIVE,
   output logic            O_SPK_LEFT_ACTIVE,
   output logic            O_SPK_RIGHT_ACTIVE,
   output logic      [1:0] O_LINE_OUT_ATTEN,
   output logic      [1:0] O_SPEAKER_ATTEN
);

   ////////////////////////////////////////////////////////////////////////////////
   // State of the bank.

   typedef struct packed {
      logic [7:0] power;
      logic [7:0] filt;
      logic [7:0] prediv;
      logic [7:0] mult;
      logic [7:0] mix;
      logic [7:0] adc;
      logic [7:0] dac;
      logic [7:0] atten;
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic [7:0] rdata;
      logic       prediv_seen;
      logic       pll_update;
   } vcr_state_s;

   vcr_state_s st_q;
   vcr_state_s st_d;

   // Returns true when the access hits the given register address.
   function automatic logic vcr_hit(input logic [3:0] addr, input logic [3:0] reg_addr);
      vcr_hit = (addr == reg_addr);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   // Writes, self-clearing soft reset, short-flag synchronisers and read data.
   always_comb begin
      logic [7:0] status;
      status = 8'h00;
      st_d = st_q;
      st_d.pll_update = 1'b0;
      // Short flags come from analog comparators outside this clock domain.
      st_d.sync1 = {I_SHORT_SPK_L, I_SHORT_SPK_R, I_SHORT_LINE};
      st_d.sync2 = st_q.sync1;
      status[vcr_pkg::BIT_SHORT_L]    = st_q.sync2[2];
      status[vcr_pkg::BIT_SHORT_R]    = st_q.sync2[1];
      status[vcr_pkg::BIT_SHORT_LINE] = st_q.sync2[0];
      if (I_WR_EN) begin
         // Reserved bits are masked on write so they always read zero.
         if (vcr_hit(I_ADDR, vcr_pkg::ADDR_POWER)) begin
            if (I_WDATA[vcr_pkg::BIT_SOFT_RESET]) begin
               // The reset bit is never stored, so it is clear again at once.
               st_d.power  = vcr_pkg::RST_POWER;
               st_d.filt   = vcr_pkg::RST_FILT;
               st_d.prediv = vcr_pkg::RST_PREDIV;
               st_d.mult   = vcr_pkg::RST_MULT;
               st_d.mix    = vcr_pkg::RST_MIX;
               st_d.adc    = vcr_pkg::RST_ADC;
               st_d.dac    = vcr_pkg::RST_DAC;
               st_d.atten  = vcr_pkg::RST_ATTEN;
               st_d.prediv_seen = 1'b0;
            end else begin
               st_d.power = I_WDATA & vcr_pkg::MASK_POWER;
            end
         end
         if (vcr_hit(I_ADDR, vcr_pkg::ADDR_FILT)) begin
            st_d.filt = I_WDATA & vcr_pkg::MASK_FILT;
         end
         if (vcr_hit(I_ADDR, vcr_pkg::ADDR_PREDIV)) begin
            st_d.prediv = I_WDATA;
         end
         if (vcr_hit(I_ADDR, vcr_pkg::ADDR_MULT)) begin
            st_d.mult = I_WDATA;
         end
         if (vcr_hit(I_ADDR, vcr_pkg::ADDR_MIX)) begin
            st_d.mix = I_WDATA;
         end
         if (vcr_hit(I_ADDR, vcr_pkg::ADDR_ADC)) begin
            st_d.adc = I_WDATA & vcr_pkg::MASK_VOL;
         end
         if (vcr_hit(I_ADDR, vcr_pkg::ADDR_DAC)) begin
            st_d.dac = I_WDATA & vcr_pkg::MASK_VOL;
         end
         if (vcr_hit(I_ADDR, vcr_pkg::ADDR_ATTEN)) begin
            st_d.atten = I_WDATA & vcr_pkg::MASK_ATTEN;
         end
         // The PLL takes new factors when the multiplier write follows the
         // predivider write directly; any other write breaks the pair.
         st_d.prediv_seen = vcr_hit(I_ADDR, vcr_pkg::ADDR_PREDIV);
         st_d.pll_update  = vcr_hit(I_ADDR, vcr_pkg::ADDR_MULT) && st_q.prediv_seen;
      end
      // Read data; address zero and unlisted addresses return zero.
      if (I_RD_EN) begin
         case (I_ADDR)
            vcr_pkg::ADDR_ZERO:   st_d.rdata = 8'h00;
            vcr_pkg::ADDR_POWER:  st_d.rdata = st_q.power;
            vcr_pkg::ADDR_FILT:   st_d.rdata = st_q.filt;
            vcr_pkg::ADDR_PREDIV: st_d.rdata = st_q.prediv;
            vcr_pkg::ADDR_MULT:   st_d.rdata = st_q.mult;
            vcr_pkg::ADDR_MIX:    st_d.rdata = st_q.mix;
            vcr_pkg::ADDR_ADC:    st_d.rdata = st_q.adc;
            vcr_pkg::ADDR_DAC:    st_d.rdata = st_q.dac;
            vcr_pkg::ADDR_STATUS: st_d.rdata = status;
            vcr_pkg::ADDR_ATTEN:  st_d.rdata = st_q.atten;
            default:              st_d.rdata = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register.

   // Asynchronous reset loads the documented reset values.
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         st_q.power       <= vcr_pkg::RST_POWER;
         st_q.filt        <= vcr_pkg::RST_FILT;
         st_q.prediv      <= vcr_pkg::RST_PREDIV;
         st_q.mult        <= vcr_pkg::RST_MULT;
         st_q.mix         <= vcr_pkg::RST_MIX;
         st_q.adc         <= vcr_pkg::RST_ADC;
         st_q.dac         <= vcr_pkg::RST_DAC;
         st_q.atten       <= vcr_pkg::RST_ATTEN;
         st_q.sync1       <= 3'h0;
         st_q.sync2       <= 3'h0;
         st_q.rdata       <= 8'h00;
         st_q.prediv_seen <= 1'b0;
         st_q.pll_update  <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control outputs, all decoded from register bits.

   // Power and mode controls.
   assign O_RDATA           = st_q.rdata;
   assign O_SPK_DRIVE_EN    = st_q.power[vcr_pkg::BIT_SPK_DRIVE];
   assign O_LINE_DRIVE_EN   = st_q.power[vcr_pkg::BIT_LINE_DRIVE];
   assign O_HSET_DRIVE_EN   = st_q.power[vcr_pkg::BIT_HSET_DRIVE];
   assign O_MIC_BIAS_OFF    = st_q.power[vcr_pkg::BIT_MIC_BIAS];
   assign O_CHIP_SLEEP      = st_q.power[vcr_pkg::BIT_SLEEP];
   assign O_HIGHPASS_BYPASS = st_q.filt[vcr_pkg::BIT_HP_BYPASS];
   assign O_PLL_DIV10       = st_q.filt[vcr_pkg::BIT_PLL_DIV10];
   assign O_ANALOG_LOOPBACK = st_q.filt[vcr_pkg::BIT_ALOOP];
   assign O_MOD_LOOPBACK    = st_q.filt[vcr_pkg::BIT_MLOOP];

   // PLL factors are the stored values plus one; both zero bypasses the PLL.
   assign O_PLL_PREDIV_FACTOR = {1'b0, st_q.prediv} + 9'h001;
   assign O_PLL_MULT_FACTOR   = {1'b0, st_q.mult} + 9'h001;
   assign O_PLL_BYPASS        = (st_q.prediv == 8'h00) && (st_q.mult == 8'h00);
   assign O_PLL_UPDATE        = st_q.pll_update;

   // Mixer routing and gains; the reserved line gain code is passed through as is.
   assign O_LINE_IN_GAIN   = st_q.mix[vcr_pkg::POS_LINE_GAIN +: 2];
   assign O_LINE_IN_TO_MIX = ~st_q.mix[vcr_pkg::BIT_LINE_MUTE];
   assign O_MIC_GAIN       = st_q.mix[vcr_pkg::POS_MIC_GAIN +: 2];
   assign O_MIC_TO_MIX     = ~st_q.mix[vcr_pkg::BIT_MIC_MUTE];
   assign O_HSET_IN_TO_MIX = ~st_q.mix[vcr_pkg::BIT_HSET_MUTE];
   assign O_IIR_SELECT     = st_q.mix[vcr_pkg::BIT_IIR];

   // Converter gains and output enables.
   assign O_ADC_PGA_GAIN     = st_q.adc[vcr_pkg::POS_PGA_GAIN +: 5];
   assign O_DAC_PGA_GAIN     = st_q.dac[vcr_pkg::POS_PGA_GAIN +: 5];
   assign O_LINE_OUT_ACTIVE  = st_q.adc[vcr_pkg::BIT_OUT_HI];
   assign O_HSET_OUT_ACTIVE  = st_q.adc[vcr_pkg::BIT_OUT_LO];
   assign O_SPK_LEFT_ACTIVE  = st_q.dac[vcr_pkg::BIT_OUT_HI];
   assign O_SPK_RIGHT_ACTIVE = st_q.dac[vcr_pkg::BIT_OUT_LO];

   // Analog attenuation codes.
   assign O_LINE_OUT_ATTEN = st_q.atten[vcr_pkg::POS_LINE_ATTEN +: 2];
   assign O_SPEAKER_ATTEN  = st_q.atten[vcr_pkg::POS_SPK_ATTEN +: 2];

endmodule

// ===== bench/vcr_regs_sva.sv
// Checker of the codec control bank outputs against its write and read strobes.
`timescale 1ns/1ps
module vcr_regs_sva (
   input wire logic       I_CLK,
   input wire logic       I_RESET_N,
   input wire logic       I_WR_EN,
   input wire logic       I_RD_EN,
   input wire logic [3:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic [7:0] O_RDATA,
   input wire logic       O_SPK_DRIVE_EN,
   input wire logic       O_LINE_DRIVE_EN,
   input wire logic       O_HSET_DRIVE_EN,
   input wire logic       O_MIC_BIAS_OFF,
   input wire logic       O_CHIP_SLEEP,
   input wire logic       O_HIGHPASS_BYPASS,
   input wire logic       O_PLL_DIV10,
   input wire logic       O_ANALOG_LOOPBACK,
   input wire logic       O_MOD_LOOPBACK,
   input wire logic [8:0] O_PLL_PREDIV_FACTOR,
   input wire logic [8:0] O_PLL_MULT_FACTOR,
   input wire logic       O_PLL_BYPASS,
   input wire logic       O_PLL_UPDATE,
   input wire logic [4:0] O_DAC_PGA_GAIN,
   input wire logic       O_SPK_LEFT_ACTIVE,
   input wire logic       O_SPK_RIGHT_ACTIVE,
   input wire logic [1:0] O_LINE_OUT_ATTEN,
   input wire logic [1:0] O_SPEAKER_ATTEN
);
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RESET_N);
   // Write strobes decoded per register.
   wire logic w_pwr = I_WR_EN && I_ADDR == vcr_pkg::ADDR_POWER;
   wire logic w_flt = I_WR_EN && I_ADDR == vcr_pkg::ADDR_FILT;
   wire logic w_dac = I_WR_EN && I_ADDR == vcr_pkg::ADDR_DAC;
   wire logic w_att = I_WR_EN && I_ADDR == vcr_pkg::ADDR_ATTEN;
   wire logic w_mul = I_WR_EN && I_ADDR == vcr_pkg::ADDR_MULT;
   // Remembers whether the most recent write went to the predivider.
   logic last_pre_q;
   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         last_pre_q <= 1'b0;
      end else if (I_WR_EN) begin
         last_pre_q <= (I_ADDR == vcr_pkg::ADDR_PREDIV);
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_drive_bits: assert property (w_pwr && !I_WDATA[7] |=>
      {O_SPK_DRIVE_EN, O_LINE_DRIVE_EN, O_HSET_DRIVE_EN, O_MIC_BIAS_OFF, O_CHIP_SLEEP}
      == $past(I_WDATA[4:0])) else $error("power control bits wrong after write");
   a_soft_reset: assert property (w_pwr && I_WDATA[7] |=> !O_SPK_DRIVE_EN && O_PLL_BYPASS
      && {O_DAC_PGA_GAIN, O_SPK_LEFT_ACTIVE, O_SPK_RIGHT_ACTIVE} == 7'h5c)
      else $error("soft reset did not restore outputs");
   a_filter_loop: assert property (w_flt |=>
      {O_HIGHPASS_BYPASS, O_PLL_DIV10, O_ANALOG_LOOPBACK, O_MOD_LOOPBACK}
      == $past(I_WDATA[4:1])) else $error("filter and loopback bits wrong");
   a_pll_plus_one: assert property (I_WR_EN && I_ADDR == vcr_pkg::ADDR_PREDIV |=>
      O_PLL_PREDIV_FACTOR == {1'b0, $past(I_WDATA)} + 9'h001) else $error("predivider wrong");
   a_pll_bypass: assert property (O_PLL_BYPASS ==
      (O_PLL_PREDIV_FACTOR == 9'h001 && O_PLL_MULT_FACTOR == 9'h001)) else $error("bypass wrong");
   a_dac_fields: assert property (w_dac |=>
      {O_DAC_PGA_GAIN, O_SPK_LEFT_ACTIVE, O_SPK_RIGHT_ACTIVE} == $past(I_WDATA[6:0]))
      else $error("dac volume fields wrong");
   a_atten_fields: assert property (w_att |=>
      {O_LINE_OUT_ATTEN, O_SPEAKER_ATTEN} == $past(I_WDATA[3:0])) else $error("atten wrong");
   a_pll_update: assert property (O_PLL_UPDATE == $past(w_mul && last_pre_q))
      else $error("pll update pulse wrong");
   a_zero_read: assert property (I_RD_EN && I_ADDR == vcr_pkg::ADDR_ZERO |-> ##1
      O_RDATA == 8'h00) else $error("address zero read not zero");
   a_status_low: assert property (I_RD_EN && I_ADDR == vcr_pkg::ADDR_STATUS |-> ##1
      O_RDATA[4:0] == 5'h00) else $error("status reserved bits not zero");
   // Main scenarios reached.
   c_soft_reset: cover property (w_pwr && I_WDATA[7]);
   c_bypass_off: cover property ($fell(O_PLL_BYPASS));
   c_status_set: cover property (I_RD_EN && I_ADDR == vcr_pkg::ADDR_STATUS ##1 O_RDATA[7]);
endmodule
bind vcr_regs vcr_regs_sva u_sva (.*);

// ===== bench/vcr_host.sv
// Host model issuing one-cycle register writes and reads on the strobe interface.
`timescale 1ns/1ps
module vcr_host (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   output logic            o_wr_en,
   output logic            o_rd_en,
   output logic      [3:0] o_addr,
   output logic      [7:0] o_wdata
);
   // Idle bus at time zero.
   initial begin
      o_wr_en = 1'b0;
      o_rd_en = 1'b0;
      o_addr  = 4'h0;
      o_wdata = 8'h00;
   end
   // Write; a released bus shows inverted values so stale data never matches.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_wr_en <= 1'b1;
      o_addr  <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_wr_en <= 1'b0;
      o_addr  <= ~a;
      o_wdata <= ~d;
      #1;
   endtask
   // Read; data is taken one edge after the registered answer lands.
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_rd_en <= 1'b1;
      o_addr  <= a;
      @(posedge i_clk);
      o_rd_en <= 1'b0;
      o_addr  <= ~a;
      @(posedge i_clk);
      #1;
      d = i_rdata;
   endtask
endmodule

// ===== bench/test_voice_codec_control_registers.sv
// Self-checking bench of the codec control bank driven through the host model.
`timescale 1ns/1ps
module test_voice_codec_control_registers;
   logic        I_CLK = 1'b0;
   logic        I_RESET_N = 1'b0;
   logic        I_SHORT_SPK_L = 1'b0, I_SHORT_SPK_R = 1'b0, I_SHORT_LINE = 1'b0;
   logic        I_WR_EN, I_RD_EN, O_SPK_DRIVE_EN, O_LINE_DRIVE_EN, O_HSET_DRIVE_EN;
   logic        O_MIC_BIAS_OFF, O_CHIP_SLEEP, O_HIGHPASS_BYPASS, O_PLL_DIV10;
   logic        O_ANALOG_LOOPBACK, O_MOD_LOOPBACK, O_PLL_BYPASS, O_PLL_UPDATE;
   logic        O_LINE_IN_TO_MIX, O_MIC_TO_MIX, O_HSET_IN_TO_MIX, O_IIR_SELECT;
   logic        O_LINE_OUT_ACTIVE, O_HSET_OUT_ACTIVE, O_SPK_LEFT_ACTIVE, O_SPK_RIGHT_ACTIVE;
   logic [1:0]  O_LINE_IN_GAIN, O_MIC_GAIN, O_LINE_OUT_ATTEN, O_SPEAKER_ATTEN;
   logic [3:0]  I_ADDR;
   logic [4:0]  O_ADC_PGA_GAIN, O_DAC_PGA_GAIN;
   logic [7:0]  I_WDATA, O_RDATA, rd_v;
   logic [8:0]  O_PLL_PREDIV_FACTOR, O_PLL_MULT_FACTOR;
   logic [7:0]  sh [16];
   logic [31:0] seed = 32'haf36;
   int          fails = 0, n_compared = 0;
   int          n_upd = 0, exp_upd = 0;
   logic [3:0]  last_a = 4'h0;
   wire logic [53:0] ctl_obs = {O_SPK_DRIVE_EN, O_LINE_DRIVE_EN, O_HSET_DRIVE_EN,
      O_MIC_BIAS_OFF, O_CHIP_SLEEP, O_HIGHPASS_BYPASS, O_PLL_DIV10, O_ANALOG_LOOPBACK,
      O_MOD_LOOPBACK, O_LINE_IN_GAIN, O_LINE_IN_TO_MIX, O_MIC_GAIN, O_MIC_TO_MIX,
      O_HSET_IN_TO_MIX, O_IIR_SELECT, O_ADC_PGA_GAIN, O_LINE_OUT_ACTIVE, O_HSET_OUT_ACTIVE,
      O_DAC_PGA_GAIN, O_SPK_LEFT_ACTIVE, O_SPK_RIGHT_ACTIVE, O_LINE_OUT_ATTEN,
      O_SPEAKER_ATTEN, O_PLL_PREDIV_FACTOR, O_PLL_MULT_FACTOR, O_PLL_BYPASS};
   vcr_regs u_dut (.*);
   vcr_host u_host (.i_clk(I_CLK), .i_rdata(O_RDATA), .o_wr_en(I_WR_EN),
                    .o_rd_en(I_RD_EN), .o_addr(I_ADDR), .o_wdata(I_WDATA));
   // Master clock, 100 ns period.
   always #50 I_CLK = ~I_CLK;
   // Counts update pulses away from the launching edge.
   always @(negedge I_CLK) if (O_PLL_UPDATE === 1'b1) n_upd++;
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Bits that a write can change; all else reads zero apart from the status short flags.
   function automatic logic [7:0] wmask(input logic [3:0] a);
      case (a)
         4'h1: return 8'h1f;
         4'h2: return 8'h1e;
         4'h3, 4'h4, 4'h5: return 8'hff;
         4'h6, 4'h7: return 8'h7f;
         4'h9: return 8'h0f;
         default: return 8'h00;
      endcase
   endfunction
   // Expected pins: mute bits 5, 2 and 1 of the mixer register are inverted.
   function automatic logic [53:0] ctl_exp();
      return {sh[1][4:0], sh[2][4:1], sh[5] ^ 8'h26, sh[6][6:0], sh[7][6:0], sh[9][3:0],
              {1'b0, sh[3]} + 9'h001, {1'b0, sh[4]} + 9'h001, sh[3] == 8'h00 && sh[4] == 8'h00};
   endfunction
   function automatic logic [7:0] rexp(input logic [3:0] a);
      return (a == 4'h8) ? {I_SHORT_SPK_L, I_SHORT_SPK_R, I_SHORT_LINE, 5'h00} : sh[a];
   endfunction
   task automatic sh_reset();
      foreach (sh[i]) sh[i] = 8'h00;
      sh[5] = 8'h47;
      sh[6] = 8'h5c;
      sh[7] = 8'h5c;
   endtask
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Reads every address, unmapped ones included, against the shadow.
   task automatic scan();
      for (int a = 0; a < 16; a++) begin
         u_host.rd(4'(a), rd_v);
         check(rd_v, rexp(4'(a)));
      end
      check(ctl_obs, ctl_exp());
   endtask
   // Write, then check every control pin except the PLL update pulse, and the read-back.
   task automatic put(input logic [3:0] a, input logic [7:0] d);
      u_host.wr(a, d);
      if (a == 4'h4 && last_a == 4'h3) exp_upd++;
      last_a = a;
      if (a == 4'h1 && d[7]) sh_reset();
      else sh[a] = d & wmask(a);
      check(ctl_obs, ctl_exp());
      u_host.rd(a, rd_v);
      check(rd_v, rexp(a));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset, corners, random traffic, soft and hard reset, shorts.
   initial begin
      logic [3:0] a;
      sh_reset();
      repeat (4) @(posedge I_CLK);
      I_RESET_N <= 1'b1;
      scan();
      put(4'h0, 8'hff);
      put(4'h8, 8'h00);
      repeat (300) begin
         seed = lfsr(seed);
         a = 4'(seed[7:0] % 9) + 4'h1;
         put((a == 4'h4) ? 4'h3 : a, seed[15:8] & wmask(a));
         if (a == 4'h3 || a == 4'h4) put(4'h4, seed[23:16]);
      end
      foreach (sh[i]) if (i > 2 && i < 5) put(4'(i), 8'hff);
      put(4'h1, 8'h9f);
      scan();
      for (int v = 0; v < 2; v++) for (int r = 3; r < 5; r++) put(4'(r), 8'(v * 255));
      @(posedge I_CLK) I_RESET_N <= 1'b0;
      repeat (2) @(posedge I_CLK);
      I_RESET_N <= 1'b1;
      sh_reset();
      scan();
      for (int k = 0; k < 8; k++) begin
         @(posedge I_CLK) {I_SHORT_SPK_L, I_SHORT_SPK_R, I_SHORT_LINE} <= 3'(k);
         repeat (3) @(posedge I_CLK);
         u_host.rd(4'h8, rd_v);
         check(rd_v, rexp(4'h8));
      end
      repeat (2) @(posedge I_CLK);
      check(n_upd, exp_upd);
      stop_test();
   end
   // Watchdog against a hung sequence.
   initial begin
      repeat (20000) @(posedge I_CLK);
      fails++;
      stop_test();
   end
endmodule
